// *** pkg/ivm_map.vh ***
`ifndef IVM_MAP_VH
`define IVM_MAP_VH
// ------------------------------------------------------------
// Vector map constants
// ------------------------------------------------------------
`define IVM_NUM_SRC 25
`define IVM_ADDR_W 14
`define IVM_RESET_ADDR 14'h0000
`define IVM_SLOT_TWO_WORD 2'h2
`define IVM_SLOT_ONE_WORD 2'h1
`define IVM_OFS_EXT0_TWO 14'h0002
`define IVM_OFS_EXT1_TWO 14'h0004
`define IVM_OFS_PCHG0_TWO 14'h0006
`define IVM_OFS_PCHG2_TWO 14'h000A
`define IVM_OFS_WDOG_TWO 14'h000C
`define IVM_OFS_C2A_TWO 14'h000E
`define IVM_OFS_C2OVF_TWO 14'h0012
`define IVM_OFS_C1CAP_TWO 14'h0014
`define IVM_OFS_C1OVF_TWO 14'h001A
`define IVM_OFS_C0A_TWO 14'h001C
`define IVM_OFS_C0OVF_TWO 14'h0020
`define IVM_OFS_SPI_TWO 14'h0022
`define IVM_OFS_RXC_TWO 14'h0024
`define IVM_OFS_TXC_TWO 14'h0028
`define IVM_OFS_ADC_TWO 14'h002A
`define IVM_OFS_STORE_TWO 14'h0032
`define IVM_OFS_FIRST_ONE 14'h0001
`define IVM_OFS_LAST_ONE 14'h0019
`define IVM_BOOT_2K_ONE 14'h0C00
`define IVM_BOOT_DEFAULT 14'h1C00
`endif

// *** verilog/ivm_prio_enc.v ***
`include "ivm_map.vh"
// ------------------------------------------------------------
// Lowest-index pending request finder
// ------------------------------------------------------------
module ivm_prio_enc #(
  parameter N = 25,
  parameter IW = 5
) (
  input wire [N-1:0] req_i, // Pending requests
  output reg any_o, // Any request pending
  output reg [IW-1:0] idx_o // Index of winner
);
  integer k;
  // Scan from the top so the lowest index is left standing
  always @*
  begin
    any_o = 1'b0;
    idx_o = {IW{1'b0}};
    for (k = N - 1; k >= 0; k = k - 1)
    begin
      if (req_i[k])
      begin
        any_o = 1'b1;
        idx_o = k[IW-1:0];
      end
    end
  end
endmodule

// *** verilog/ivm_sync.v ***
// ------------------------------------------------------------
// Two-flop synchroniser, one per bit
// ------------------------------------------------------------
module ivm_sync #(
  parameter W = 25
) (
  input wire ref_clk_i, // System clock
  input wire nrst_i, // Async reset, active low
  input wire [W-1:0] d_i, // Asynchronous levels
  output wire [W-1:0] q_o // Synchronised levels
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  // First stage feeds only the second
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end
    else
    begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end
  assign q_o = sync_r;
endmodule

// *** verilog/ivm_mapper.v ***
`include "ivm_map.vh"
module ivm_mapper #(
  parameter TWO_WORD = 1, // 1: two-word slots, 0: one-word slots
  parameter [13:0] BOOT_START = `IVM_BOOT_DEFAULT, // Boot section word start
  parameter N = `IVM_NUM_SRC,
  parameter IW = 5
) (
  input wire ref_clk_i, // System clock, 50 MHz
  input wire nrst_i, // Combined system reset, active low
  input wire boot_reset_fuse_n_i, // Fuse, 0 means programmed
  input wire vector_select_bit_i, // Vectors moved to boot section
  input wire [N-1:0] irq_i, // Requests from peripherals
  input wire irq_ack_i, // Core takes the presented vector
  output wire irq_req_o, // A request is pending
  output reg [`IVM_ADDR_W-1:0] vec_addr_o, // Vector for the core
  output reg [IW-1:0] vec_idx_o, // Winning source index
  output reg [`IVM_ADDR_W-1:0] reset_addr_o, // Start address after reset
  output reg taken_o // One-cycle pulse on acceptance
);
  localparam AW = `IVM_ADDR_W;
  localparam ST_RESET = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_HOLD = 2'h2;

  // ------------------------------------------------------------
  // Request conditioning
  // ------------------------------------------------------------
  wire [N-1:0] irq_sync;
  wire fuse_sync_n;
  wire sel_sync;
  wire any_pend;
  wire [IW-1:0] win_idx;

  // Requests and straps come from other domains, so resync them
  ivm_sync #(
    .W(N + 2)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i({boot_reset_fuse_n_i, vector_select_bit_i, irq_i}),
    .q_o({fuse_sync_n, sel_sync, irq_sync})
  );

  ivm_prio_enc #(
    .N(N),
    .IW(IW)
  ) u_prio (
    .req_i(irq_sync),
    .any_o(any_pend),
    .idx_o(win_idx)
  );

  // ------------------------------------------------------------
  // Address arithmetic
  // ------------------------------------------------------------
  // Base offset of a source: slot one is vector 1 right after reset
  function [AW-1:0] base_ofs;
    input [IW-1:0] idx;
    reg [AW-1:0] slot;
    begin
      slot = {{(AW-IW){1'b0}}, idx} + {{(AW-1){1'b0}}, 1'b1};
      if (TWO_WORD != 0)
        base_ofs = {slot[AW-2:0], 1'b0};
      else
        base_ofs = slot;
    end
  endfunction

  // Relocation into boot section when vector select is set
  function [AW-1:0] place;
    input [AW-1:0] ofs;
    input sel;
    begin
      if (sel)
        place = BOOT_START + ofs;
      else
        place = ofs;
    end
  endfunction

  // ------------------------------------------------------------
  // Presentation state
  // ------------------------------------------------------------
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg fuse_seen_r;
  reg [1:0] settle_r;

  // Stay in reset state until the synchronisers hold real input levels,
  // otherwise their reset zeros would read as a programmed fuse
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      settle_r <= 2'h0;
    else if (state_r == ST_RESET && settle_r != 2'h2)
      settle_r <= settle_r + 2'h1;
  end

  // Hold the vector stable while the core is taking it, so a late
  // higher-priority request cannot tear the address mid-fetch
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET:
        if (settle_r == 2'h2)
          state_nxt = ST_RUN;
      ST_RUN:
        if (any_pend)
          state_nxt = ST_HOLD;
      ST_HOLD:
        if (irq_ack_i)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_RESET;
    endcase
  end

  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= ST_RESET;
      vec_addr_o <= {AW{1'b0}};
      vec_idx_o <= {IW{1'b0}};
      taken_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      taken_o <= (state_r == ST_HOLD) && irq_ack_i;
      if (state_r == ST_RUN && any_pend)
      begin
        vec_idx_o <= win_idx;
        vec_addr_o <= place(base_ofs(win_idx), sel_sync);
      end
    end
  end

  assign irq_req_o = (state_r == ST_HOLD);

  // ------------------------------------------------------------
  // Reset start address
  // ------------------------------------------------------------
  // Fuse is caught after release, never loaded under reset
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fuse_seen_r <= 1'b0;
      reset_addr_o <= `IVM_RESET_ADDR;
    end
    else if (!fuse_seen_r && state_r == ST_RUN)
    begin
      fuse_seen_r <= 1'b1;
      if (!fuse_sync_n)
        reset_addr_o <= BOOT_START;
      else
        reset_addr_o <= `IVM_RESET_ADDR;
    end
  end
endmodule

// *** dv/ivm_props.sv ***
// ------------------------------------------------------------
// Vector mapper checks
// ------------------------------------------------------------
module ivm_props #(
  parameter TWO_WORD = 1,
  parameter [13:0] BOOT_START = 14'h1C00
) (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire boot_reset_fuse_n_i,
  input wire vector_select_bit_i,
  input wire [24:0] irq_i,
  input wire irq_ack_i,
  input wire irq_req_o,
  input wire [13:0] vec_addr_o,
  input wire [4:0] vec_idx_o,
  input wire [13:0] reset_addr_o,
  input wire taken_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Slot offset of the shown source, before any boot move
  wire [13:0] ofs = ({9'h000, vec_idx_o} + 14'h0001) << (TWO_WORD ? 1 : 0);
  // One clock, quiet while in reset
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_live; nrst_i [*5]; endsequence
  sequence s_take; irq_req_o && irq_ack_i; endsequence
  property p_rst; s_live |-> reset_addr_o ==
    (boot_reset_fuse_n_i ? 14'h0000 : BOOT_START); endproperty
  a_rst: assert property (p_rst) else $error("start addr");
  property p_vec; irq_req_o |->
    vec_addr_o == ofs || vec_addr_o == ofs + BOOT_START; endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_hold; irq_req_o && !irq_ack_i |=> irq_req_o &&
    $stable(vec_addr_o) && $stable(vec_idx_o); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_take; s_take |=> taken_o && !irq_req_o; endproperty
  a_take: assert property (p_take) else $error("take");
  property p_pulse; taken_o |=> !taken_o; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
  property p_cause; $rose(taken_o) |->
    $past(irq_req_o && irq_ack_i); endproperty
  a_cause: assert property (p_cause) else $error("cause");
  // Bits up to the winner, seen three edges back, are the winner alone
  property p_prio; $rose(irq_req_o) |-> ($past(irq_i, 3) &
    ((25'h000_0002 << vec_idx_o) - 25'h000_0001)) ==
    (25'h000_0001 << vec_idx_o); endproperty
  a_prio: assert property (p_prio) else $error("priority");
  property p_range; irq_req_o |-> vec_idx_o < 5'h19; endproperty
  a_range: assert property (p_range) else $error("index");
endmodule
bind ivm_mapper ivm_props #(.TWO_WORD(TWO_WORD), .BOOT_START(BOOT_START))
  u_props (.*);

// *** dv/ivm_core_model.sv ***
// Core side: takes each vector a few cycles late
module ivm_core_model (
  input wire logic clk_i, // System clock
  input wire logic irq_req_i, // Vector shown
  output logic ack_o = 0 // Vector taken
);
  timeunit 1ns;
  timeprecision 1ns;
  int c = 0, w = 0;
  // Wait 3..6 cycles so a served source drains its synchroniser
  always @(posedge clk_i)
  begin
    #1;
    c = (ack_o || irq_req_i !== 1'b1) ? 0 : c + 1;
    ack_o = c >= 3 + w;
    if (ack_o)
      w = (w + 1) % 4;
  end
endmodule

// *** dv/ivm_mapper_bench.sv ***
// ------------------------------------------------------------
// Vector mapper bench
// ------------------------------------------------------------
module ivm_mapper_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [13:0] BOOT = 14'h1C00;
  localparam [13:0] BOOT1 = 14'h0C00;
  logic [13:0] addr1, raddr1;
  logic [13:0] exp1_q[$];
  logic ref_clk_i = 0, nrst_i = 0, fuse_n = 1, sel = 0, ack, req, taken;
  logic [24:0] irq = 0;
  logic [13:0] addr, raddr;
  logic [4:0] idx;
  logic [18:0] exp_q[$];
  int failures = 0, comparisons = 0, seed = 56;
  ivm_mapper #(.BOOT_START(BOOT)) uut (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .boot_reset_fuse_n_i(fuse_n), .vector_select_bit_i(sel),
    .irq_i(irq), .irq_ack_i(ack), .irq_req_o(req), .vec_addr_o(addr),
    .vec_idx_o(idx), .reset_addr_o(raddr), .taken_o(taken));
  // One-word variant with a 2 Kbyte boot section, same inputs and core
  ivm_mapper #(.TWO_WORD(0), .BOOT_START(BOOT1)) uut1 (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .boot_reset_fuse_n_i(fuse_n), .vector_select_bit_i(sel),
    .irq_i(irq), .irq_ack_i(ack), .irq_req_o(), .vec_addr_o(addr1),
    .vec_idx_o(), .reset_addr_o(raddr1), .taken_o());
  ivm_core_model core (.clk_i(ref_clk_i), .irq_req_i(req), .ack_o(ack));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  task automatic chk(string n, logic [18:0] e, logic [18:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("Counts: %0d checks, %0d mismatches", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Reset 8 cycles at the given fuse level, then read the start address
  task automatic do_reset(logic f);
    nrst_i = 0;
    fuse_n = f;
    repeat (8) @(posedge ref_clk_i);
    #1 nrst_i = 1;
    repeat (5) @(posedge ref_clk_i);
    #1 chk("rst", {5'h00, f ? 14'h0000 : BOOT}, {5'h00, raddr});
    chk("rst1", {5'h00, f ? 14'h0000 : BOOT1}, {5'h00, raddr1});
    $display("Test done: reset fuse %b", f);
  endtask
  // Raise a set at once; the core must see them lowest index first
  task automatic burst(logic [24:0] m, logic s);
    int t;
    sel = s;
    repeat (3) @(posedge ref_clk_i);
    for (int i = 0; i < 25; i++)
      if (m[i])
      begin
        exp_q.push_back({i[4:0], (s ? BOOT : 14'h0000) + 14'((i + 1) * 2)});
        exp1_q.push_back((s ? BOOT1 : 14'h0000) + 14'(i + 1));
      end
    #1 irq = m;
    for (t = 0; t < 400 && exp_q.size() > 0; t++)
      @(posedge ref_clk_i);
    #1 $display("Test done: mask %h sel %b", m, s);
    if (t == 400)
    begin
      failures++;
      report_and_stop();
    end
  endtask
  // Served source drops at once; each accepted vector meets its note
  always @(posedge ref_clk_i)
  begin
    if (req === 1'b1)
      irq[idx] <= 1'b0;
    if (req === 1'b1 && ack === 1'b1)
    begin
      chk("v", exp_q.pop_front(), {idx, addr});
      chk("v1", {5'h00, exp1_q.pop_front()}, {5'h00, addr1});
    end
  end
  // Unprogrammed fuse at both selects, then random mixes, then the programmed fuse
  initial
  begin
    do_reset(1'b1);
    burst(25'h1FF_FFFF, 1'b0);
    burst(25'h1FF_FFFF, 1'b1);
    for (int k = 0; k < 6; k++)
      burst(25'($random(seed)), k[0]);
    do_reset(1'b0);
    burst(25'h155_5555, 1'b1);
    report_and_stop();
  end
endmodule
